// [rtl/ee_pkg.sv]
// constants, register map and types of the emulated nonvolatile store access block
package ee_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int PROG_BASE_TIME_US = 2000;
  localparam int PROG_BASE_CYCLES = PROG_BASE_TIME_US * CLK_MHZ;
  localparam int READ_TIME_NS = 20;
  localparam int READ_CYCLES = (READ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 24;
  // ****************************************
  // array geometry
  // ****************************************
  localparam int WORD_W = 15;
  localparam int ADDR_W = 5;
  localparam int NUM_WORDS = 32;
  localparam int PAGE_WORDS = 16;
  localparam int UNIT_WORDS = 4;
  localparam int DATA_REGS = 4;
  localparam int STEP_W = 5;
  localparam int PAGE_BIT = 4;
  localparam int UNIT_HI = 4;
  localparam int UNIT_LO = 2;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 7;
  // ****************************************
  // register word indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_ADDR = 6'h00;
  localparam logic [5:0] IDX_DATA_FIRST = 6'h01;
  localparam logic [5:0] IDX_DATA_LAST = 6'h08;
  localparam logic [5:0] IDX_CTRL = 6'h09;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 7;
  localparam int DECODE_TOP = 8;
  // ****************************************
  // control register fields and reset values
  // ****************************************
  localparam int BIT_READ_TRIG = 0;
  localparam int BIT_READ_EN = 1;
  localparam int BIT_WRITE_TRIG = 2;
  localparam int BIT_WRITE_EN = 3;
  localparam int BIT_ERASE_TRIG = 4;
  localparam int BIT_ERASE_EN = 5;
  localparam int TIME_SEL_LO = 6;
  localparam int TIME_SEL_HI = 7;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [WORD_W-1:0] DATA_RESET = 15'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int TRANS_ACTIVE_BIT = 1;
  // ****************************************
  // operation states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ = 2'b11
  } op_state_e;
endpackage

// [rtl/ee_array_if.sv]
// port bundle between the access controller and the storage array
`timescale 1ns/1ps
`default_nettype none
interface ee_array_if
  import ee_pkg::*;
();
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [WORD_W-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [WORD_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [rtl/ee_store.sv]
// 32 x 15 storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module ee_store
  import ee_pkg::*;
(
  input wire logic hclk,
  ee_array_if.mem arr
);
  typedef struct packed {
    logic [NUM_WORDS-1:0][WORD_W-1:0] words; // [R1]
    logic [WORD_W-1:0] rdata;
  } store_s;

  store_s r;
  store_s n;

  // ****************************************
  // array update, no reset so contents survive
  // ****************************************
  always_comb
  begin
    n = r;
    if (arr.we)
    begin
      n.words[arr.waddr] = arr.wdata;
    end
    n.rdata = r.words[arr.raddr];
  end

  always_ff @(posedge hclk)
  begin
    r <= n;
  end

  assign arr.rdata = r.rdata;
endmodule
`default_nettype wire

// [rtl/ee_access.sv]
// emulated nonvolatile store access logic with ahb-lite register slave
// Contract
// [R1] array holds 32 words of 15 bits
// [R2] erase page, write four words, read one
// [R3] erase page picked by address bit 4
// [R4] write unit picked by address bits 4:2
// [R5] software erases page before writing it
// [R6] address register five bits, upper read zero
// [R7] data words split low/high byte, top zero
// [R8] time select 2, 4, 8, 16 ms
// [R9] erase enable required, cleared at end
// [R10] erase trigger needs enable, clears when done
// [R11] write enable required, cleared at end
// [R12] write trigger needs enable, clears when done
// [R13] read enable required, never auto cleared
// [R14] read trigger needs enable, clears when done
// [R15] trigger must follow enable write directly; read trigger only needs enable already set
// [R16] enable and trigger never in one write
// [R17] processor halted while operation runs
// [R18] software ensures clocks before erase/write
// [R19] software masks interrupts around activation
// [R20] erased page reads all zero
// [R21] read result held in first data pair
// [R22] software loads address and data before write
// [R23] software avoids sleep during operations
// [R24] data pair n goes to unit word n
// [R25] ignored trigger leaves everything untouched
`timescale 1ns/1ps
`default_nettype none
module ee_access
  import ee_pkg::*;
#(
  parameter int unsigned prog_base_cycles = PROG_BASE_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic cpu_halt
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_REGS-1:0][WORD_W-1:0] data;
    logic [7:0] ctrl;
    logic arm_erase;
    logic arm_write;
    op_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic [STEP_W-1:0] step;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [WORD_W-1:0] mem_wdata;
    logic [ADDR_W-1:0] mem_raddr;
    logic dp_valid;
    logic dp_write;
    logic dp_hit;
    logic [5:0] dp_idx;
    logic hreadyout;
    logic [31:0] hrdata;
    logic resp;
    logic halt;
  } access_s;

  access_s r;
  access_s n;
  ee_array_if arr ();

  ee_store u_store (
    .hclk(hclk),
    .arr(arr.mem)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_data(input logic [5:0] idx);
    is_data = (idx >= IDX_DATA_FIRST) && (idx <= IDX_DATA_LAST);
  endfunction

  function automatic logic [1:0] data_word(input logic [5:0] idx);
    logic [5:0] rel;
    rel = idx - IDX_DATA_FIRST;
    data_word = rel[2:1];
  endfunction

  function automatic logic data_high(input logic [5:0] idx);
    logic [5:0] rel;
    rel = idx - IDX_DATA_FIRST;
    data_high = rel[0];
  endfunction

  function automatic logic [31:0] reg_read(input access_s s);
    logic [WORD_W-1:0] w;
    reg_read = 32'h00000000;
    w = s.data[data_word(s.dp_idx)];
    if (s.dp_hit)
    begin
      if (s.dp_idx == IDX_ADDR)
      begin
        reg_read = 32'(s.addr); // [R6]
      end
      else if (s.dp_idx == IDX_CTRL)
      begin
        reg_read = 32'(s.ctrl);
      end
      else if (is_data(s.dp_idx))
      begin
        if (data_high(s.dp_idx))
        begin
          reg_read = 32'(w[WORD_W-1:LOW_W]); // [R7]
        end
        else
        begin
          reg_read = 32'(w[LOW_W-1:0]); // [R7]
        end
      end
    end
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic fire;
    logic [7:0] w;
    logic [7:0] old;
    logic [1:0] wi;
    logic [CNT_W-1:0] prog_last;
    fire = 1'b0;
    w = 8'h00;
    old = 8'h00;
    wi = 2'b00;
    prog_last = '0;
    n = r;
    n.resp = 1'b0;
    n.mem_we = 1'b0;
    fire = r.dp_valid && r.hreadyout;
    w = hwdata[7:0];
    old = r.ctrl;
    wi = data_word(r.dp_idx);
    prog_last = (CNT_W'(prog_base_cycles) << r.ctrl[TIME_SEL_HI:TIME_SEL_LO]) - 1'b1; // [R8]

    // register writes in the data phase
    if (fire)
    begin
      n.arm_erase = 1'b0; // [R15]
      n.arm_write = 1'b0; // [R15]
    end
    if (fire && r.dp_write && r.dp_hit)
    begin
      if (r.dp_idx == IDX_ADDR)
      begin
        n.addr = w[ADDR_W-1:0]; // [R6]
      end
      else if (is_data(r.dp_idx))
      begin
        if (data_high(r.dp_idx))
        begin
          n.data[wi][WORD_W-1:LOW_W] = w[HIGH_W-1:0]; // [R7]
        end
        else
        begin
          n.data[wi][LOW_W-1:0] = w; // [R7]
        end
      end
      else if (r.dp_idx == IDX_CTRL)
      begin
        n.ctrl = w;
        n.ctrl[BIT_ERASE_TRIG] = 1'b0; // [R25]
        n.ctrl[BIT_WRITE_TRIG] = 1'b0; // [R25]
        n.ctrl[BIT_READ_TRIG] = 1'b0; // [R25]
        n.arm_erase = w[BIT_ERASE_EN] && !w[BIT_ERASE_TRIG]; // [R15] [R16]
        n.arm_write = w[BIT_WRITE_EN] && !w[BIT_WRITE_TRIG]; // [R15] [R16]
        if (w[BIT_ERASE_TRIG] && w[BIT_ERASE_EN] && old[BIT_ERASE_EN] && r.arm_erase) // [R9] [R10]
        begin
          n.ctrl[BIT_ERASE_TRIG] = 1'b1; // [R10]
          n.state = ST_ERASE;
          n.last = (CNT_W'(prog_base_cycles) << w[TIME_SEL_HI:TIME_SEL_LO]) - 1'b1; // [R8]
        end
        else if (w[BIT_WRITE_TRIG] && w[BIT_WRITE_EN] && old[BIT_WRITE_EN] && r.arm_write) // [R11] [R12]
        begin
          n.ctrl[BIT_WRITE_TRIG] = 1'b1; // [R12]
          n.state = ST_WRITE;
          n.last = (CNT_W'(prog_base_cycles) << w[TIME_SEL_HI:TIME_SEL_LO]) - 1'b1; // [R8]
        end
        else if (w[BIT_READ_TRIG] && w[BIT_READ_EN] && old[BIT_READ_EN]) // [R13] [R14]
        begin
          n.ctrl[BIT_READ_TRIG] = 1'b1; // [R14]
          n.state = ST_READ;
          n.last = CNT_W'(READ_CYCLES - 1);
        end
        if (n.state != ST_IDLE)
        begin
          n.cnt = '0;
          n.step = '0;
          n.mem_raddr = r.addr; // [R2]
          n.hreadyout = 1'b0; // [R17]
          n.halt = 1'b1; // [R17]
        end
      end
    end

    // running operation
    if (r.state != ST_IDLE)
    begin
      n.cnt = r.cnt + 1'b1;
      if (r.state == ST_ERASE && r.step < STEP_W'(PAGE_WORDS))
      begin
        n.mem_we = 1'b1;
        n.mem_waddr = {r.addr[PAGE_BIT], r.step[3:0]}; // [R2] [R3]
        n.mem_wdata = DATA_RESET; // [R20]
        n.step = r.step + 1'b1;
      end
      if (r.state == ST_WRITE && r.step < STEP_W'(UNIT_WORDS))
      begin
        n.mem_we = 1'b1;
        n.mem_waddr = {r.addr[UNIT_HI:UNIT_LO], r.step[1:0]}; // [R2] [R4]
        n.mem_wdata = r.data[r.step[1:0]]; // [R24]
        n.step = r.step + 1'b1;
      end
      if (r.cnt == r.last)
      begin
        n.state = ST_IDLE;
        n.hreadyout = 1'b1; // [R17]
        n.halt = 1'b0; // [R17]
        unique case (r.state)
          ST_ERASE:
          begin
            n.ctrl[BIT_ERASE_EN] = 1'b0; // [R9]
            n.ctrl[BIT_ERASE_TRIG] = 1'b0; // [R10]
          end
          ST_WRITE:
          begin
            n.ctrl[BIT_WRITE_EN] = 1'b0; // [R11]
            n.ctrl[BIT_WRITE_TRIG] = 1'b0; // [R12]
          end
          ST_READ:
          begin
            n.ctrl[BIT_READ_TRIG] = 1'b0; // [R14]
            n.data[0] = arr.rdata; // [R21]
          end
          ST_IDLE:
          begin
            n.state = ST_IDLE;
          end
        endcase
      end
    end

    // address phase capture
    if (hready)
    begin
      n.dp_valid = hsel && htrans[TRANS_ACTIVE_BIT];
      n.dp_write = hwrite;
      n.dp_idx = haddr[IDX_HI:IDX_LO];
      n.dp_hit = (haddr[31:DECODE_TOP] == '0) && (haddr[IDX_HI:IDX_LO] <= IDX_CTRL);
    end
    n.hrdata = reg_read(n);
    if (prog_last == '0)
    begin
      n.last = n.last;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.addr <= ADDR_RESET;
      r.ctrl <= CTRL_RESET;
      r.state <= ST_IDLE;
      r.hreadyout <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign arr.we = r.mem_we;
  assign arr.waddr = r.mem_waddr;
  assign arr.wdata = r.mem_wdata;
  assign arr.raddr = r.mem_raddr;
  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = r.resp;
  assign cpu_halt = r.halt;
endmodule
`default_nettype wire

// [verif/ee_access_chk.sv]
// assertions on the bus and halt ports of the access block
`timescale 1ns/1ps
`default_nettype none
module ee_access_chk
  import ee_pkg::*;
#(
  parameter int unsigned prog_base_cycles = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic cpu_halt
);
  // ****
  // data phase tracking
  // ****
  logic dp_reg;
  logic dp_wr_reg;
  logic [5:0] dp_idx_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
      dp_idx_reg <= 6'h00;
    end
    else if (hready)
    begin
      dp_reg <= hsel && htrans[1];
      dp_wr_reg <= hwrite;
      dp_idx_reg <= haddr[7:2];
    end
  end
  wire logic rd_done = dp_reg && hreadyout && !dp_wr_reg;
  wire logic ctl_wr = dp_reg && hreadyout && dp_wr_reg && dp_idx_reg == IDX_CTRL;
  wire logic trig_wr = ctl_wr && (hwdata[4] || hwdata[2] || hwdata[0]);
  wire logic prog_wr = ctl_wr && (hwdata[4] || hwdata[2]) && !hwdata[0];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****
  // properties
  // ****
  a_stall_halt: assert property (!hreadyout |-> cpu_halt)
    else $error("stall without halt");
  a_halt_stall: assert property (cpu_halt |-> !hreadyout)
    else $error("halt without stall");
  a_halt_cause: assert property ($rose(cpu_halt) |-> $past(trig_wr))
    else $error("halt without trigger write");
  a_halt_ends: assert property ($rose(cpu_halt) |-> ##[1:300] !cpu_halt)
    else $error("halt too long");
  a_halt_min: assert property ($rose(cpu_halt) |-> cpu_halt[*4])
    else $error("halt too short");
  a_prog_min: assert property ($rose(cpu_halt) && $past(prog_wr) |-> cpu_halt[*8])
    else $error("program time too short");
  a_addr_zero: assert property (rd_done && dp_idx_reg == IDX_ADDR |-> hrdata[31:5] == 0)
    else $error("address upper bits set");
  a_high_zero: assert property (rd_done && dp_idx_reg inside {2, 4, 6, 8}
    |-> hrdata[31:7] == 0)
    else $error("high byte top bit set");
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the access block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ee_pkg::*;
;
  localparam int B = 32;
  localparam logic [31:0] CTL = 32'h24;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic cpu_halt;
  int err_count = 0;
  int tests_run = 0;
  int hcnt = 0;
  int mem[32];
  int d[4];
  int s;
  logic [31:0] x;
  logic [31:0] r;
  ee_access #(.prog_base_cycles(B)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_halt(cpu_halt)
  );
  always #2.5 hclk = ~hclk;
  always @(posedge hclk)
    if (cpu_halt === 1'b1)
      hcnt <= hcnt + 1;
  // ****
  // tasks
  // ****
  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    x = hrdata;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] v);
    xfer(1'b1, ad, v);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] e, input string n);
    xfer(1'b0, ad, 32'h0);
    chk(x, e, n);
    chk(32'(hresp), 32'h0, "response");
  endtask
  task automatic op(input logic [31:0] ad, input logic [31:0] v1, input logic [31:0] v2,
    input int n, input logic [31:0] ec);
    int h0;
    h0 = hcnt;
    wr(ad, v1);
    wr(CTL, v2);
    rd(CTL, ec, "control");
    chk(hcnt - h0, n, "halt cycles");
  endtask
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h8360a9f2));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(4 * i, 32'h0, "reset value");
    for (int i = 0; i < 9; i++)
    begin
      r = $urandom;
      wr(4 * i, r);
      rd(4 * i, r & (i == 0 ? 32'h1f : i % 2 ? 32'hff : 32'h7f), "register");
    end
    wr(CTL, 32'hc0);
    rd(CTL, 32'hc0, "time select");
    op(CTL, 32'h00, 32'h15, 0, 32'h00);
    op(CTL, 32'h00, 32'h30, 0, 32'h20);
    op(32'h0, 32'h5, 32'h30, 0, 32'h20);
    op(CTL, 32'h00, 32'h0c, 0, 32'h08);
    for (int p = 0; p < 2; p++)
    begin
      s = p << 6;
      wr(32'h0, p * 16 + $urandom % 16);
      op(CTL, 32'h20 | s, 32'h30 | s, B << p, s);
      for (int i = 0; i < 16; i++)
        mem[p * 16 + i] = 0;
    end
    for (int u = 0; u < 8; u++)
    begin
      s = (u % 4) << 6;
      wr(32'h0, u * 4 + $urandom % 4);
      for (int n = 0; n < 4; n++)
      begin
        d[n] = $urandom % 32768;
        mem[u * 4 + n] = d[n];
        wr(4 + 8 * n, d[n] % 256);
        wr(8 + 8 * n, d[n] / 256);
      end
      op(CTL, 32'h08 | s, 32'h0c | s, B << (u % 4), s);
    end
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 32; i++)
      begin
        wr(32'h0, i);
        op(CTL, 32'h02, 32'h03, READ_CYCLES, 32'h02);
        rd(32'h4, mem[i] % 256, "word low");
        rd(32'h8, mem[i] / 256, "word high");
      end
      wr(32'h0, 32'h10 | $urandom % 16);
      op(CTL, 32'ha0, 32'hb0, B << 2, 32'h80);
      for (int i = 16; i < 32; i++)
        mem[i] = 0;
    end
    give_verdict();
  end
endmodule
bind ee_access ee_access_chk #(.prog_base_cycles(prog_base_cycles)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_halt(cpu_halt)
);
`default_nettype wire
